// ### spfrd_pkg.sv
package spfrd_pkg;
   // ---------------------------------------------------------------
   // frame layout
   // ---------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int DATA_MSB = 5;
   localparam int DATA_LSB = 0;
   localparam int FAULT_BITS = 12;
   localparam int CHANNELS = 6;
   localparam int GROUP_LO = 0;
   localparam int GROUP_HI = 3;
   localparam int RETRY_BIT = 2;
   // ---------------------------------------------------------------
   // register addresses, reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_GATE = 4'h0;
   localparam logic [3:0] ADDR_RESPONSE = 4'h1;
   localparam logic [3:0] ADDR_RETRY = 4'h2;
   localparam logic [3:0] ADDR_MASK = 4'h3;
   localparam logic [5:0] REG_RESET = 6'h00;
   localparam logic [3:0] REPLY_TOP = 4'h0;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int RETRY_SHORT_MS = 10;
   localparam int RETRY_LONG_MS = 40;
   localparam int RETRY_SHORT_CYC = CLK_HZ / 1000 * RETRY_SHORT_MS;
   localparam int RETRY_LONG_CYC = CLK_HZ / 1000 * RETRY_LONG_MS;
   localparam int RETRY_W = 21;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [5:0] gate_on_select;
      logic [5:0] shorted_load_response;
      logic [5:0] retry_time_and_threshold;
      logic [5:0] flag_mask;
   } spfrd_cfg_t;

   typedef struct packed {
      logic chip_select_n;
      logic sclk;
      logic si;
   } spfrd_spi_t;
endpackage : spfrd_pkg

// ### spfrd_top.sv
`timescale 1ns/1ps
// Operation
// RULE1 - reply: zero top nibble, twelve fault bits
// RULE2 - command splits into address and data
// RULE3 - address top four bits, data low six
// RULE4 - host keeps frame top bit zero
// RULE5 - address zero holds gate select bits
// RULE6 - gate also gated by reset, enables, short
// RULE7 - gate select bits reset to zero
// RULE8 - address one holds latch-off or retry mode
// RULE9 - response mode bits reset to zero
// RULE10 - address two: two three-bit channel groups
// RULE11 - low two bits pick shorted-load threshold
// RULE12 - upper group bit picks 10/40 ms retry
// RULE13 - commit only at select rise, valid frame
// RULE14 - address three holds flag mask, reset zero
// RULE15 - top address bit set stores nothing
// RULE16 - gate high: enables, no short, input or select
// RULE17 - bits eleven to six ignored
// RULE18 - write replaces whole addressed register
module spfrd_top
   import spfrd_pkg::*;
#(
   parameter int RETRY_SHORT = RETRY_SHORT_CYC,
   parameter int RETRY_LONG = RETRY_LONG_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial link pins
   input wire spfrd_spi_t spi_in,
   output logic so_q,
   output logic so_oe_n_q,
   // enables and parallel inputs
   input wire logic soft_reset_enable,
   input wire logic output_disable_enable,
   input wire logic [5:0] parallel_in,
   // fault side
   input wire logic [11:0] fault_data,
   input wire logic [5:0] shorted_load_state,
   // gate and configuration outputs
   output logic [5:0] gate_drive_out_q,
   output spfrd_cfg_t cfg_q,
   output logic [1:0] fault_threshold_lo_q,
   output logic [1:0] fault_threshold_hi_q,
   output logic [RETRY_W-1:0] retry_period_lo_q,
   output logic [RETRY_W-1:0] retry_period_hi_q,
   output logic frame_error_q
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   spfrd_spi_t spi_m_q, spi_s_q, spi_p_q;
   logic [7:0] pin_m_q, pin_s_q;
   logic soft_reset_enable_s, output_disable_enable_s;
   logic [5:0] par_s;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         spi_m_q <= '{chip_select_n: 1'b1, sclk: 1'b0, si: 1'b0};
         spi_s_q <= '{chip_select_n: 1'b1, sclk: 1'b0, si: 1'b0};
         spi_p_q <= '{chip_select_n: 1'b1, sclk: 1'b0, si: 1'b0};
         pin_m_q <= 8'h00;
         pin_s_q <= 8'h00;
      end else begin
         spi_m_q <= spi_in;
         spi_s_q <= spi_m_q;
         spi_p_q <= spi_s_q;
         pin_m_q <= {soft_reset_enable, output_disable_enable, parallel_in};
         pin_s_q <= pin_m_q;
      end
   end

   assign soft_reset_enable_s = pin_s_q[7];
   assign output_disable_enable_s = pin_s_q[6];
   assign par_s = pin_s_q[5:0];

   logic sclk_rise, sclk_fall, cs_fall, cs_rise;
   assign sclk_rise = spi_s_q.sclk & ~spi_p_q.sclk & ~spi_s_q.chip_select_n;
   assign sclk_fall = ~spi_s_q.sclk & spi_p_q.sclk & ~spi_s_q.chip_select_n;
   assign cs_fall = ~spi_s_q.chip_select_n & spi_p_q.chip_select_n;
   assign cs_rise = spi_s_q.chip_select_n & ~spi_p_q.chip_select_n;

   // ---------------------------------------------------------------
   // receive shift and frame length check
   // ---------------------------------------------------------------
   logic [15:0] rx_q;
   logic [3:0] cnt_q;
   logic full_q;
   logic frame_ok;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_q <= 16'h0000;
         cnt_q <= 4'h0;
         full_q <= 1'b0;
      end else if (cs_fall) begin
         cnt_q <= 4'h0;
         full_q <= 1'b0;
      end else if (sclk_rise) begin
         rx_q <= {rx_q[14:0], spi_s_q.si};
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == 4'hF)
            full_q <= 1'b1;
      end
   end

   // whole multiple of sixteen: rx holds the last complete word
   assign frame_ok = full_q && (cnt_q == 4'h0);

   always_ff @(posedge clk) begin
      if (!resetn)
         frame_error_q <= 1'b0;
      else if (cs_rise)
         frame_error_q <= ~frame_ok;
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   logic [3:0] cmd_addr;
   logic [5:0] cmd_data;
   logic commit;

   assign cmd_addr = rx_q[ADDR_MSB:ADDR_LSB]; // RULE2 RULE3
   assign cmd_data = rx_q[DATA_MSB:DATA_LSB]; // RULE3 RULE17
   assign commit = cs_rise & frame_ok; // RULE13

   // full decode: frame top bit set or null addresses store nothing
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_q <= '{REG_RESET, REG_RESET, REG_RESET, REG_RESET}; // RULE7 RULE9 RULE10 RULE14
      end else begin
         if (!soft_reset_enable_s)
            cfg_q.gate_on_select <= REG_RESET; // RULE6
         else if (commit && cmd_addr == ADDR_GATE) // RULE15
            cfg_q.gate_on_select <= cmd_data; // RULE5 RULE18
         if (commit && cmd_addr == ADDR_RESPONSE)
            cfg_q.shorted_load_response <= cmd_data; // RULE8 RULE18
         if (commit && cmd_addr == ADDR_RETRY)
            cfg_q.retry_time_and_threshold <= cmd_data; // RULE10 RULE18
         if (commit && cmd_addr == ADDR_MASK)
            cfg_q.flag_mask <= cmd_data; // RULE14 RULE18
      end
   end

   // ---------------------------------------------------------------
   // threshold and retry period per group
   // ---------------------------------------------------------------
   logic [5:0] rtt;
   assign rtt = cfg_q.retry_time_and_threshold;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fault_threshold_lo_q <= 2'h0;
         fault_threshold_hi_q <= 2'h0;
         retry_period_lo_q <= RETRY_W'(RETRY_SHORT);
         retry_period_hi_q <= RETRY_W'(RETRY_SHORT);
      end else begin
         // 00/01/10/11 = 25/50/75/100 percent of the reference
         fault_threshold_lo_q <= rtt[GROUP_LO+1:GROUP_LO]; // RULE11
         fault_threshold_hi_q <= rtt[GROUP_HI+1:GROUP_HI]; // RULE11
         retry_period_lo_q <= rtt[GROUP_LO+RETRY_BIT] ?
            RETRY_W'(RETRY_LONG) : RETRY_W'(RETRY_SHORT); // RULE12
         retry_period_hi_q <= rtt[GROUP_HI+RETRY_BIT] ?
            RETRY_W'(RETRY_LONG) : RETRY_W'(RETRY_SHORT); // RULE12
      end
   end

   // ---------------------------------------------------------------
   // gate drive
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn)
         gate_drive_out_q <= 6'h00; // RULE6
      else
         gate_drive_out_q <= {6{soft_reset_enable_s & output_disable_enable_s}} & ~shorted_load_state
            & (par_s | cfg_q.gate_on_select); // RULE16 RULE6
   end

   // ---------------------------------------------------------------
   // reply shift
   // ---------------------------------------------------------------
   logic [15:0] tx_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_q <= 16'h0000;
         so_q <= 1'b0;
         so_oe_n_q <= 1'b1;
      end else begin
         so_oe_n_q <= spi_s_q.chip_select_n;
         if (cs_fall) begin
            tx_q <= {REPLY_TOP, fault_data}; // RULE1
            so_q <= REPLY_TOP[3]; // RULE1
         end else if (sclk_fall) begin
            tx_q <= {tx_q[14:0], 1'b0};
            so_q <= tx_q[14];
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   reply_top_zero_a: assert property ( // RULE1
      cs_fall |=> tx_q[15:12] == 4'h0 && tx_q[11:0] == $past(fault_data)
         && so_q == 1'b0)
      else $error("reply top nibble not zero or fault field wrong");

   gate_write_a: assert property ( // RULE5
      commit && cmd_addr == 4'h0 && soft_reset_enable_s
         |=> cfg_q.gate_on_select == $past(cmd_data))
      else $error("gate select write lost");

   response_write_a: assert property ( // RULE8
      commit && cmd_addr == 4'h1
         |=> cfg_q.shorted_load_response == $past(cmd_data)
         && $stable(cfg_q.flag_mask))
      else $error("response mode write wrong");

   mask_write_a: assert property ( // RULE14
      commit && cmd_addr == 4'h3
         |=> cfg_q.flag_mask == $past(cmd_data)
         && $stable(cfg_q.shorted_load_response))
      else $error("flag mask write wrong");

   null_store_a: assert property ( // RULE15
      commit && cmd_addr[2] && soft_reset_enable_s |=> $stable(cfg_q))
      else $error("null address changed a register");

   bad_frame_a: assert property ( // RULE13
      cs_rise && !frame_ok && soft_reset_enable_s |=> $stable(cfg_q) && frame_error_q)
      else $error("register changed on a bad frame");

   gate_level_a: assert property ( // RULE16
      ##1 gate_drive_out_q == ($past({6{soft_reset_enable_s & output_disable_enable_s}})
         & ~$past(shorted_load_state)
         & ($past(par_s) | $past(cfg_q.gate_on_select))))
      else $error("gate output does not follow its inputs");

   soft_reset_gate_a: assert property ( // RULE6
      !soft_reset_enable_s [*2] |-> cfg_q.gate_on_select == 6'h00
         && gate_drive_out_q == 6'h00)
      else $error("gate not cleared while soft reset held");

   retry_select_a: assert property ( // RULE12
      rtt[5] ##1 rtt[5] |-> retry_period_hi_q == RETRY_W'(RETRY_LONG))
      else $error("long retry period not selected");

   threshold_sel_a: assert property ( // RULE11
      $stable(rtt) |-> fault_threshold_lo_q == rtt[1:0]
         && fault_threshold_hi_q == rtt[4:3])
      else $error("threshold code does not follow register");
endmodule : spfrd_top

// ### spfrd_host.sv
`timescale 1ns/1ps
module spfrd_host
   import spfrd_pkg::*;
(
   // link
   input wire logic clk,
   input wire logic so,
   output spfrd_spi_t spi_o
);
   // ---------------------------------------------------------------
   // host master: select pulled up, clock and data pulled down
   // ---------------------------------------------------------------
   initial spi_o = '{chip_select_n: 1'b1, sclk: 1'b0, si: 1'b0};

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // one frame, msb first; the word repeats when nbits exceeds 16
   task automatic xfer(input logic [15:0] cmd, input int nbits,
         output logic [15:0] rep);
      rep = 16'h0000;
      spi_o.chip_select_n <= 1'b0;
      tick(4);
      for (int i = 0; i < nbits; i++) begin
         spi_o.si <= (i % 16 == 0) ? 1'b0 : cmd[15 - (i % 16)];
         tick(4);
         spi_o.sclk <= 1'b1;
         if (i < 16) rep[15 - i] = so;
         tick(4);
         spi_o.sclk <= 1'b0;
      end
      tick(4);
      spi_o.chip_select_n <= 1'b1;
      spi_o.si <= 1'b0;
      tick(48);
   endtask : xfer
endmodule : spfrd_host

// ### testbench.sv
`timescale 1ns/1ps
module testbench
   import spfrd_pkg::*;
;
   localparam int R_SHORT = 10;
   localparam int R_LONG = 40;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic soft_reset_enable = 1'b1;
   logic output_disable_enable = 1'b1;
   logic [5:0] parallel_in = 6'h00;
   logic [5:0] shorted_load_state = 6'h00;
   logic [11:0] fault_data = 12'hA5C;
   spfrd_spi_t spi;
   logic so_q, so_oe_n_q, frame_error_q;
   logic [5:0] gate_drive_out_q;
   spfrd_cfg_t cfg_q;
   logic [1:0] th_lo, th_hi, c;
   logic [RETRY_W-1:0] rp_lo, rp_hi;
   logic [15:0] rep;
   logic [3:0] nulls [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
   // released reply line shows the inverse of the last bit
   wire so_line;
   assign so_line = so_oe_n_q ? ~so_q : so_q;
   int n_errors = 0;
   int num_checks = 0;

   always #12.5 clk = ~clk;

   spfrd_host spfrd_host_i (.clk(clk), .so(so_line), .spi_o(spi));

   spfrd_top #(.RETRY_SHORT(R_SHORT), .RETRY_LONG(R_LONG)) spfrd_top_i (
      .clk(clk), .resetn(resetn), .spi_in(spi), .so_q(so_q),
      .so_oe_n_q(so_oe_n_q), .soft_reset_enable(soft_reset_enable),
      .output_disable_enable(output_disable_enable),
      .parallel_in(parallel_in), .fault_data(fault_data),
      .shorted_load_state(shorted_load_state),
      .gate_drive_out_q(gate_drive_out_q), .cfg_q(cfg_q),
      .fault_threshold_lo_q(th_lo), .fault_threshold_hi_q(th_hi),
      .retry_period_lo_q(rp_lo), .retry_period_hi_q(rp_hi),
      .frame_error_q(frame_error_q));

   task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up

   // write with junk in the ignored middle bits
   task automatic wr(logic [3:0] a, logic [5:0] d);
      spfrd_host_i.xfer({a, 6'h3F, d}, 16, rep);
      chk("reply", rep, {8'h00, 4'h0, fault_data});
      chk("so_oe_n", so_oe_n_q, 24'h1);
   endtask : wr

   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk("gate_sel", cfg_q.gate_on_select, 24'h0);
      chk("response", cfg_q.shorted_load_response, 24'h0);
      chk("retry_cfg", cfg_q.retry_time_and_threshold, 24'h0);
      chk("mask", cfg_q.flag_mask, 24'h0);
      chk("retry_lo", rp_lo, R_SHORT);
      wr(ADDR_GATE, 6'h2D);
      chk("gate_sel", cfg_q.gate_on_select, 24'h2D);
      chk("gate", gate_drive_out_q, 24'h2D);
      chk("retry_cfg", cfg_q.retry_time_and_threshold, 24'h0);
      shorted_load_state <= 6'h01;
      parallel_in <= 6'h10;
      repeat (4) @(posedge clk);
      chk("gate", gate_drive_out_q, 24'h3C);
      output_disable_enable <= 1'b0;
      repeat (4) @(posedge clk);
      chk("gate", gate_drive_out_q, 24'h0);
      output_disable_enable <= 1'b1;
      shorted_load_state <= 6'h00;
      parallel_in <= 6'h00;
      soft_reset_enable <= 1'b0;
      wr(ADDR_GATE, 6'h3F);
      chk("gate_sel", cfg_q.gate_on_select, 24'h0);
      soft_reset_enable <= 1'b1;
      wr(ADDR_RESPONSE, 6'h15);
      chk("response", cfg_q.shorted_load_response, 24'h15);
      for (int k = 0; k < 4; k++) begin
         c = 2'(k);
         wr(ADDR_RETRY, {~c[0], ~c, c[0], c});
         chk("th_lo", th_lo, c);
         chk("th_hi", th_hi, 2'(~c));
         chk("rp_lo", rp_lo, c[0] ? R_LONG : R_SHORT);
         chk("rp_hi", rp_hi, c[0] ? R_SHORT : R_LONG);
      end
      wr(ADDR_MASK, 6'h3F);
      chk("mask", cfg_q.flag_mask, 24'h3F);
      foreach (nulls[i]) wr(nulls[i], 6'h2A);
      chk("cfg", cfg_q, {6'h00, 6'h15, 6'h07, 6'h3F});
      spfrd_host_i.xfer({ADDR_GATE, 6'h00, 6'h3F}, 15, rep);
      chk("frame_err", frame_error_q, 24'h1);
      chk("gate_sel", cfg_q.gate_on_select, 24'h0);
      spfrd_host_i.xfer({ADDR_GATE, 6'h00, 6'h21}, 32, rep);
      chk("frame_err", frame_error_q, 24'h0);
      chk("gate_sel", cfg_q.gate_on_select, 24'h21);
      chk("gate", gate_drive_out_q, 24'h21);
      // second reset in mid-run with every register loaded
      resetn <= 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk("cfg", cfg_q, 24'h0);
      chk("gate", gate_drive_out_q, 24'h0);
      chk("retry_lo", rp_lo, R_SHORT);
      wrap_up();
   end
endmodule : testbench
